// *** design/occ_pkg.sv ***
// Package: register map, fields, reset values and timing counts for oscillator control
package occ_pkg;
  localparam logic [7:0]  OCC_OSC_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  OCC_TUNE_OFS       = 8'h10;
  localparam logic [7:0]  OCC_REF_CTRL_OFS   = 8'h20;
  localparam logic [7:0]  OCC_UNLOCK_OFS     = 8'h30;
  localparam logic [7:0]  OCC_STATUS_OFS     = 8'h34;
  localparam logic [31:0] OCC_UNLOCK_KEY1    = 32'hAA99_6655;
  localparam logic [31:0] OCC_UNLOCK_KEY2    = 32'h5566_99AA;
  localparam int OCC_PBDIV_LSB   = 19;
  localparam int OCC_PLLMUL_LSB  = 16;
  localparam int OCC_CUR_LSB     = 12;
  localparam int OCC_NEW_LSB     = 8;
  localparam int OCC_LOCK_BIT    = 7;
  localparam int OCC_USBLK_BIT   = 6;
  localparam int OCC_SYSLK_BIT   = 5;
  localparam int OCC_SLEEP_BIT   = 4;
  localparam int OCC_FAIL_BIT    = 3;
  localparam int OCC_USBRC_BIT   = 2;
  localparam int OCC_SEC_BIT     = 1;
  localparam int OCC_SWREQ_BIT   = 0;
  localparam int OCC_DIVRDY_BIT  = 21;
  localparam int OCC_RDIV_LSB    = 16;
  localparam int OCC_ON_BIT      = 15;
  localparam int OCC_REF_STOP_IN_IDLE_BIT    = 13;
  localparam int OCC_OE_BIT      = 12;
  localparam int OCC_REF_RUN_IN_SLEEP_BIT    = 11;
  localparam int OCC_DSW_BIT     = 9;
  localparam int OCC_ACT_BIT     = 8;
  localparam logic [5:0]  OCC_TUNE_RST   = 6'h00;
  localparam logic [14:0] OCC_RDIV_RST   = 15'h0000;
  localparam logic [3:0]  OCC_RSEL_RST   = 4'h0;
  localparam int OCC_SWITCH_NS   = 100;
  localparam int OCC_CLK_MHZ     = 100;
  localparam int OCC_SWITCH_CYC  = (OCC_SWITCH_NS * OCC_CLK_MHZ + 999) / 1000;
  localparam logic [2:0]  OCC_SRC_RC       = 3'h0;
  localparam logic [2:0]  OCC_SRC_RC_PLL   = 3'h1;
  localparam logic [2:0]  OCC_SRC_PRI_PLL  = 3'h3;
  localparam logic [3:0]  OCC_REF_SYS      = 4'h0;
  localparam logic [3:0]  OCC_REF_PB       = 4'h1;
  localparam logic [3:0]  OCC_REF_EXT      = 4'h8;
endpackage

// *** design/occ_pb_div.sv ***
// Peripheral bus enable divider
`timescale 1ns/10ps
`default_nettype none
module occ_pb_div
  import occ_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [1:0] divisor,
  output logic            pb_en
);
  logic [2:0] cnt_reg;
  logic [2:0] limit;

  always_comb begin
    case (divisor)
      2'h3:    limit = 3'h7;
      2'h2:    limit = 3'h3;
      2'h1:    limit = 3'h1;
      default: limit = 3'h0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt_reg <= 3'h0;
      pb_en   <= 1'b0;
    end else if (cnt_reg >= limit) begin
      cnt_reg <= 3'h0;
      pb_en   <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
      pb_en   <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** design/occ_ref_div.sv ***
// Reference clock divider, toggles its output every divider plus one ticks
`timescale 1ns/10ps
`default_nettype none
module occ_ref_div
  import occ_pkg::*;
#(
  parameter int DW = 15
) (
  input  wire logic          mclk,
  input  wire logic          rst_b,
  input  wire logic          run,
  input  wire logic          tick,
  input  wire logic [DW-1:0] divider,
  output logic               ref_clk
);
  logic [DW-1:0] cnt_reg;

  always_ff @(posedge mclk) begin
    if (!rst_b || !run) begin
      cnt_reg <= '0;
      ref_clk <= 1'b0;
    end else if (tick) begin
      if (cnt_reg >= divider) begin
        cnt_reg <= '0;
        ref_clk <= ~ref_clk;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** design/occ_osc_ctrl.sv ***
// Oscillator control and status registers with AXI4-Lite slave and reference clock output
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module occ_osc_ctrl
  import occ_pkg::*;
#(
  parameter int SWITCH_CYC = OCC_SWITCH_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        por_b,
  input  wire logic [1:0]  cfg_periph_divisor_default,
  input  wire logic [2:0]  cfg_pll_multiplier_default,
  input  wire logic [2:0]  cfg_source_default,
  input  wire logic [1:0]  cfg_switch_monitor,
  input  wire logic        usb_pll_lock_in,
  input  wire logic        usb_pll_timer_done,
  input  wire logic        sys_pll_lock_in,
  input  wire logic        sys_pll_timer_done,
  input  wire logic        fail_safe_monitor,
  input  wire logic        wait_exec,
  input  wire logic        divisor_ready_in,
  input  wire logic        ref_clock_in_pin,
  input  wire logic        ref_request,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [1:0]       periph_bus_divisor,
  output logic [2:0]       pll_multiplier,
  output logic [2:0]       current_source_sel,
  output logic             secondary_osc_enable,
  output logic             usb_rc_select,
  output logic             enter_sleep,
  output logic             enter_idle,
  output logic             periph_bus_clock,
  output logic             ref_clock_out_pin,
  output logic             ref_clock_out_oe_b
);
  typedef enum logic [1:0] {OCC_LK_IDLE, OCC_LK_KEY1, OCC_LK_OPEN} occ_lock_e;

  logic [2:0]  new_source_sel;
  logic        selection_lock;
  logic        sleep_select;
  logic        clock_fail_flag;
  logic        switch_request;
  logic [5:0]  rc_tune_value;
  logic [14:0] ref_divider;
  logic [14:0] ref_div_pending;
  logic        ref_on;
  logic        ref_stop_in_idle;
  logic        ref_oe;
  logic        ref_run_in_sleep;
  logic        divider_switch;
  logic        ref_active;
  logic [3:0]  ref_source_sel;
  logic        usb_pll_locked;
  logic        sys_pll_locked;
  logic        divisor_ready;
  logic        in_sleep;
  logic        in_idle;
  logic [2:0]  ext_sync;
  logic        ext_lvl;
  logic        ext_rise;
  logic [15:0] sw_cnt_reg;
  occ_lock_e   lk_state;
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;
  logic        rd_go;
  logic        sel_locked;
  logic        prot_ok;
  logic [31:0] osc_word;
  logic [31:0] ref_word;
  logic [31:0] rd_word;
  logic        pb_tick;
  logic        ref_tick;
  logic        ref_run;
  logic        ref_wave;

  assign wr_go      = aw_hold && w_hold && !s_axi_bvalid;
  assign rd_go      = s_axi_arvalid && s_axi_arready;
  assign sel_locked = cfg_switch_monitor[1] && selection_lock;
  assign prot_ok    = (lk_state == OCC_LK_OPEN);

  // Write address and data accepted in either order
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_hold && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          OCC_OSC_CTRL_OFS, OCC_TUNE_OFS, OCC_REF_CTRL_OFS, OCC_UNLOCK_OFS: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel, one outstanding
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        case (s_axi_araddr)
          OCC_OSC_CTRL_OFS, OCC_TUNE_OFS, OCC_REF_CTRL_OFS, OCC_UNLOCK_OFS, OCC_STATUS_OFS: s_axi_rresp <= 2'h0;
          default: s_axi_rresp <= 2'h2;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    osc_word = 32'h0000_0000;
    osc_word[OCC_DIVRDY_BIT] = divisor_ready;
    osc_word[OCC_PBDIV_LSB +: 2] = periph_bus_divisor;
    osc_word[OCC_PLLMUL_LSB +: 3] = pll_multiplier;
    osc_word[OCC_CUR_LSB +: 3] = current_source_sel;
    osc_word[OCC_NEW_LSB +: 3] = new_source_sel;
    osc_word[OCC_LOCK_BIT] = selection_lock;
    osc_word[OCC_USBLK_BIT] = usb_pll_locked;
    osc_word[OCC_SYSLK_BIT] = sys_pll_locked;
    osc_word[OCC_SLEEP_BIT] = sleep_select;
    osc_word[OCC_FAIL_BIT] = clock_fail_flag;
    osc_word[OCC_USBRC_BIT] = usb_rc_select;
    osc_word[OCC_SEC_BIT] = secondary_osc_enable;
    osc_word[OCC_SWREQ_BIT] = switch_request;
    ref_word = 32'h0000_0000;
    ref_word[OCC_RDIV_LSB +: 15] = ref_divider;
    ref_word[OCC_ON_BIT] = ref_on;
    ref_word[OCC_REF_STOP_IN_IDLE_BIT] = ref_stop_in_idle;
    ref_word[OCC_OE_BIT] = ref_oe;
    ref_word[OCC_REF_RUN_IN_SLEEP_BIT] = ref_run_in_sleep;
    ref_word[OCC_DSW_BIT] = divider_switch;
    ref_word[OCC_ACT_BIT] = ref_active;
    ref_word[3:0] = ref_source_sel;
    case (s_axi_araddr)
      OCC_OSC_CTRL_OFS: rd_word = osc_word;
      OCC_TUNE_OFS:     rd_word = {26'h0, rc_tune_value};
      OCC_REF_CTRL_OFS: rd_word = ref_word;
      OCC_UNLOCK_OFS:   rd_word = {31'h0, prot_ok};
      OCC_STATUS_OFS:   rd_word = {29'h0, in_idle, in_sleep, ref_wave};
      default:          rd_word = 32'h0000_0000;
    endcase
  end

  // Unlock sequence: two keys, then one protected write
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      lk_state <= OCC_LK_IDLE;
    end else if (wr_go) begin
      case (lk_state)
        OCC_LK_IDLE: lk_state <= (aw_addr == OCC_UNLOCK_OFS && w_data == OCC_UNLOCK_KEY1) ? OCC_LK_KEY1 : OCC_LK_IDLE;
        OCC_LK_KEY1: lk_state <= (aw_addr == OCC_UNLOCK_OFS && w_data == OCC_UNLOCK_KEY2) ? OCC_LK_OPEN : OCC_LK_IDLE;
        OCC_LK_OPEN: lk_state <= OCC_LK_IDLE;
        default:     lk_state <= OCC_LK_IDLE;
      endcase
    end
  end

  // Fields loaded from configuration on power-on only
  always_ff @(posedge mclk) begin
    if (!por_b) begin
      periph_bus_divisor <= cfg_periph_divisor_default;
      pll_multiplier     <= cfg_pll_multiplier_default;
    end else if (wr_go && prot_ok && aw_addr == OCC_OSC_CTRL_OFS && w_strb[2]) begin
      if (divisor_ready) begin
        periph_bus_divisor <= w_data[OCC_PBDIV_LSB +: 2];
      end
      if (!sel_locked) begin
        pll_multiplier <= w_data[OCC_PLLMUL_LSB +: 3];
      end
    end
  end

  // Oscillator control bits and clock switch
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      new_source_sel       <= cfg_source_default;
      current_source_sel   <= cfg_source_default;
      selection_lock       <= 1'b0;
      sleep_select         <= 1'b0;
      usb_rc_select        <= 1'b0;
      secondary_osc_enable <= 1'b0;
      switch_request       <= 1'b0;
      sw_cnt_reg           <= 16'h0000;
    end else begin
      if (switch_request) begin
        if (sw_cnt_reg >= 16'(SWITCH_CYC - 1)) begin
          switch_request     <= 1'b0;
          current_source_sel <= new_source_sel;
          sw_cnt_reg         <= 16'h0000;
        end else begin
          sw_cnt_reg <= sw_cnt_reg + 16'h0001;
        end
      end
      if (wr_go && prot_ok && aw_addr == OCC_OSC_CTRL_OFS) begin
        if (w_strb[1] && !sel_locked && !switch_request) begin
          new_source_sel <= w_data[OCC_NEW_LSB +: 3];
        end
        if (w_strb[0]) begin
          if (!selection_lock || !cfg_switch_monitor[1]) begin
            selection_lock <= w_data[OCC_LOCK_BIT];
          end
          sleep_select         <= w_data[OCC_SLEEP_BIT];
          usb_rc_select        <= w_data[OCC_USBRC_BIT];
          secondary_osc_enable <= w_data[OCC_SEC_BIT];
          if (w_data[OCC_SWREQ_BIT] && !sel_locked && !switch_request) begin
            switch_request <= 1'b1;
          end
        end
      end
    end
  end

  // Clock fail: set wins over clear-on-read
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      clock_fail_flag <= 1'b0;
    end else if (fail_safe_monitor) begin
      clock_fail_flag <= 1'b1;
    end else if (rd_go && s_axi_araddr == OCC_OSC_CTRL_OFS) begin
      clock_fail_flag <= 1'b0;
    end
  end

  // Status inputs and power mode
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      usb_pll_locked <= 1'b0;
      sys_pll_locked <= 1'b0;
      divisor_ready  <= 1'b0;
      in_sleep       <= 1'b0;
      in_idle        <= 1'b0;
      enter_sleep    <= 1'b0;
      enter_idle     <= 1'b0;
    end else begin
      usb_pll_locked <= usb_pll_lock_in || usb_pll_timer_done;
      sys_pll_locked <= sys_pll_lock_in || sys_pll_timer_done;
      divisor_ready  <= divisor_ready_in;
      enter_sleep    <= wait_exec && sleep_select;
      enter_idle     <= wait_exec && !sleep_select;
      if (wait_exec) begin
        in_sleep <= sleep_select;
        in_idle  <= !sleep_select;
      end else if (ref_request) begin
        in_sleep <= 1'b0;
        in_idle  <= 1'b0;
      end
    end
  end

  // Tuning register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rc_tune_value <= OCC_TUNE_RST;
    end else if (wr_go && prot_ok && aw_addr == OCC_TUNE_OFS && w_strb[0]) begin
      rc_tune_value <= w_data[5:0];
    end
  end

  // Reference clock control
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ref_on           <= 1'b0;
      ref_stop_in_idle <= 1'b0;
      ref_oe           <= 1'b0;
      ref_run_in_sleep <= 1'b0;
      ref_source_sel   <= OCC_RSEL_RST;
      ref_divider      <= OCC_RDIV_RST;
      ref_div_pending  <= OCC_RDIV_RST;
      divider_switch   <= 1'b0;
    end else begin
      if (divider_switch) begin
        ref_divider    <= ref_div_pending;
        divider_switch <= 1'b0;
      end
      if (wr_go && aw_addr == OCC_REF_CTRL_OFS) begin
        if (w_strb[3] && w_strb[2]) begin
          ref_div_pending <= w_data[OCC_RDIV_LSB +: 15];
          if (!ref_on) begin
            ref_divider <= w_data[OCC_RDIV_LSB +: 15];
          end
        end
        if (w_strb[1]) begin
          ref_on           <= w_data[OCC_ON_BIT];
          ref_stop_in_idle <= w_data[OCC_REF_STOP_IN_IDLE_BIT];
          ref_oe           <= w_data[OCC_OE_BIT];
          ref_run_in_sleep <= w_data[OCC_REF_RUN_IN_SLEEP_BIT];
          if (w_data[OCC_DSW_BIT]) begin
            divider_switch <= 1'b1;
          end
        end
        if (w_strb[0] && !ref_active && w_data[3:0] <= OCC_REF_EXT) begin
          ref_source_sel <= w_data[3:0];
        end
      end
    end
  end

  // External reference input synchroniser
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ext_sync <= 3'h0;
      ext_lvl  <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[1:0], ref_clock_in_pin};
      if (ext_sync[1] == ext_sync[2]) begin
        ext_lvl <= ext_sync[2];
      end
    end
  end

  assign ext_rise = ext_sync[1] && ext_sync[2] && !ext_lvl;

  always_comb begin
    case (ref_source_sel)
      OCC_REF_SYS: ref_tick = 1'b1;
      OCC_REF_PB:  ref_tick = pb_tick;
      OCC_REF_EXT: ref_tick = ext_rise;
      default:     ref_tick = (ref_source_sel <= OCC_REF_EXT);
    endcase
  end

  assign ref_run = ref_on && !(in_idle && ref_stop_in_idle)
                 && !(in_sleep && (ref_source_sel <= OCC_REF_PB || !ref_run_in_sleep));

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ref_active         <= 1'b0;
      ref_clock_out_pin  <= 1'b0;
      ref_clock_out_oe_b <= 1'b1;
      periph_bus_clock   <= 1'b0;
    end else begin
      ref_active         <= ref_on && ref_request;
      ref_clock_out_pin  <= ref_oe && ref_wave;
      ref_clock_out_oe_b <= !(ref_oe && ref_on);
      periph_bus_clock   <= pb_tick;
    end
  end

  occ_pb_div u_pb_div (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .divisor (periph_bus_divisor),
    .pb_en   (pb_tick)
  );

  occ_ref_div #(.DW(15)) u_ref_div (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .run     (ref_run),
    .tick    (ref_tick),
    .divider (ref_divider),
    .ref_clk (ref_wave)
  );
endmodule
`default_nettype wire

// *** testbench/occ_osc_ctrl_chk.sv ***
// Port checker for the oscillator control block
`timescale 1ns/10ps
`default_nettype none
module occ_osc_ctrl_chk (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        por_b,
  input wire logic [1:0]  cfg_periph_divisor_default,
  input wire logic [2:0]  cfg_pll_multiplier_default,
  input wire logic        wait_exec,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  periph_bus_divisor,
  input wire logic [2:0]  pll_multiplier,
  input wire logic        enter_sleep,
  input wire logic        enter_idle,
  input wire logic        periph_bus_clock
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_mode_cause;
    (enter_sleep || enter_idle) |-> $past(wait_exec);
  endproperty
  a_mode_cause: assert property (p_mode_cause) else $error("mode pulse without wait");
  property p_wait_mode;
    wait_exec |=> enter_sleep ^ enter_idle;
  endproperty
  a_wait_mode: assert property (p_wait_mode) else $error("wait gave no single mode");
  property p_one_pulse;
    enter_sleep |=> !enter_sleep;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("sleep pulse too long");
  property p_div8;
    periph_bus_clock && periph_bus_divisor == 2'h3 |=> !periph_bus_clock || periph_bus_divisor != 2'h3;
  endproperty
  a_div8: assert property (p_div8) else $error("divide by eight pulse too close");
  property p_div2;
    periph_bus_clock && periph_bus_divisor == 2'h1 |=> !periph_bus_clock ##1
      (periph_bus_clock || $changed(periph_bus_divisor));
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two spacing wrong");
  property p_div1;
    $past(rst_b, 2) && $past(periph_bus_divisor, 2) == 2'h0 && $past(periph_bus_divisor) == 2'h0
      && periph_bus_divisor == 2'h0 |-> periph_bus_clock;
  endproperty
  a_div1: assert property (p_div1) else $error("divide by one pulse missing");
  property p_por;
    !por_b |=> periph_bus_divisor == $past(cfg_periph_divisor_default)
      && pll_multiplier == $past(cfg_pll_multiplier_default);
  endproperty
  a_por: assert property (p_por) else $error("power-on load wrong");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule
bind occ_osc_ctrl occ_osc_ctrl_chk u_chk (.mclk, .rst_b, .por_b, .cfg_periph_divisor_default,
  .cfg_pll_multiplier_default, .wait_exec, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .periph_bus_divisor, .pll_multiplier, .enter_sleep, .enter_idle,
  .periph_bus_clock);
`default_nettype wire

// *** testbench/test_occ_osc_ctrl.sv ***
// Self-checking bench for the oscillator control block
`timescale 1ns/10ps
`default_nettype none
module test_occ_osc_ctrl;
  import occ_pkg::*;
  logic        mclk = 1'h0, rst_b = 1'h0, por_b = 1'h0;
  logic [1:0]  cfg_periph_divisor_default = 2'h3, cfg_switch_monitor = 2'h0;
  logic [2:0]  cfg_pll_multiplier_default = 3'h5, cfg_source_default = 3'h2;
  logic        usb_pll_lock_in = 1'h0, usb_pll_timer_done = 1'h0, sys_pll_lock_in = 1'h0;
  logic        sys_pll_timer_done = 1'h0, fail_safe_monitor = 1'h0, wait_exec = 1'h0;
  logic        divisor_ready_in = 1'h1, ref_clock_in_pin = 1'h0, ref_request = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, br, rr, periph_bus_divisor;
  logic [2:0]  pll_multiplier, current_source_sel;
  logic        secondary_osc_enable, usb_rc_select, enter_sleep, enter_idle, periph_bus_clock;
  logic        ref_clock_out_pin, ref_clock_out_oe_b;
  int          bad_count = 0, cmp_count = 0;
  always #5 mclk = ~mclk;
  occ_osc_ctrl DUT (.mclk, .rst_b, .por_b, .cfg_periph_divisor_default, .cfg_pll_multiplier_default,
    .cfg_source_default, .cfg_switch_monitor, .usb_pll_lock_in, .usb_pll_timer_done, .sys_pll_lock_in,
    .sys_pll_timer_done, .fail_safe_monitor, .wait_exec, .divisor_ready_in, .ref_clock_in_pin, .ref_request,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periph_bus_divisor, .pll_multiplier, .current_source_sel,
    .secondary_osc_enable, .usb_rc_select, .enter_sleep, .enter_idle, .periph_bus_clock,
    .ref_clock_out_pin, .ref_clock_out_oe_b);
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(negedge mclk);
      ha = s_axi_awready;
      hw = s_axi_wready;
      hb = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge mclk);
      if (ha) s_axi_awvalid <= 1'h0;
      if (hw) s_axi_wvalid <= 1'h0;
      if (hb) break;
    end
    s_axi_bready <= 1'h0;
  endtask
  task automatic rdr(input logic [7:0] a);
    logic ha, hr;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(negedge mclk);
      ha = s_axi_arready;
      hr = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge mclk);
      if (ha) s_axi_arvalid <= 1'h0;
      if (hr) break;
    end
    s_axi_rready <= 1'h0;
  endtask
  task automatic unl_wr(input logic [7:0] a, input logic [31:0] d);
    wr(OCC_UNLOCK_OFS, OCC_UNLOCK_KEY1);
    wr(OCC_UNLOCK_OFS, OCC_UNLOCK_KEY2);
    wr(a, d);
  endtask
  task automatic pulse_wait(input logic s);
    @(posedge mclk);
    wait_exec <= 1'h1;
    @(posedge mclk);
    wait_exec <= 1'h0;
    @(negedge mclk);
    chk("enter_sleep", enter_sleep, s);
    chk("enter_idle", enter_idle, !s);
    @(posedge mclk);
  endtask
  // Oscillator control word; multiplier kept at its loaded value
  function automatic logic [31:0] ow(input logic [1:0] dv, input logic [2:0] ns, input logic [7:0] lo);
    return (32'(dv) << OCC_PBDIV_LSB) | (32'h5 << OCC_PLLMUL_LSB) | (32'(ns) << OCC_NEW_LSB) | 32'(lo);
  endfunction
  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'h1;
    por_b <= 1'h1;
    rdr(OCC_OSC_CTRL_OFS);
    chk("pbdiv", rd[OCC_PBDIV_LSB +: 2], 32'h3);
    chk("pllmul", rd[OCC_PLLMUL_LSB +: 3], 32'h5);
    chk("newsrc", rd[OCC_NEW_LSB +: 3], 32'h2);
    chk("pbdiv_out", periph_bus_divisor, 32'h3);
    rdr(OCC_REF_CTRL_OFS);
    chk("refctl", rd, 32'h0);
    $display("test reset done");
    wr(OCC_TUNE_OFS, 32'hFFFF_FFFF);
    rdr(OCC_TUNE_OFS);
    chk("tune_locked", rd, 32'h0);
    unl_wr(OCC_TUNE_OFS, 32'hFFFF_FFFF);
    rdr(OCC_TUNE_OFS);
    chk("tune", rd, 32'h3F);
    $display("test unlock done");
    unl_wr(OCC_OSC_CTRL_OFS, ow(2'h1, 3'h4, 8'h17));
    rdr(OCC_OSC_CTRL_OFS);
    for (int i = 0; i < 20 && rd[OCC_SWREQ_BIT] !== 1'h0; i++) rdr(OCC_OSC_CTRL_OFS);
    chk("swreq", rd[OCC_SWREQ_BIT], 32'h0);
    chk("cur_field", rd[OCC_CUR_LSB +: 3], 32'h4);
    chk("cur_out", current_source_sel, 32'h4);
    chk("sec_en", secondary_osc_enable, 32'h1);
    chk("usb_rc", usb_rc_select, 32'h1);
    chk("pbdiv_out", periph_bus_divisor, 32'h1);
    pulse_wait(1'h1);
    unl_wr(OCC_OSC_CTRL_OFS, ow(2'h1, 3'h0, 8'h80));
    pulse_wait(1'h0);
    unl_wr(OCC_OSC_CTRL_OFS, ow(2'h1, 3'h1, 8'h80));
    rdr(OCC_OSC_CTRL_OFS);
    chk("newsrc_free", rd[OCC_NEW_LSB +: 3], 32'h1);
    chk("sec_off", secondary_osc_enable, 32'h0);
    cfg_switch_monitor <= 2'h2;
    unl_wr(OCC_OSC_CTRL_OFS, ow(2'h1, 3'h5, 8'h80));
    rdr(OCC_OSC_CTRL_OFS);
    chk("newsrc_locked", rd[OCC_NEW_LSB +: 3], 32'h1);
    cfg_switch_monitor <= 2'h0;
    $display("test switch done");
    fail_safe_monitor <= 1'h1;
    @(posedge mclk);
    fail_safe_monitor <= 1'h0;
    sys_pll_lock_in <= 1'h1;
    usb_pll_timer_done <= 1'h1;
    rdr(OCC_OSC_CTRL_OFS);
    chk("cf_set", rd[OCC_FAIL_BIT], 32'h1);
    chk("sys_lock", rd[OCC_SYSLK_BIT], 32'h1);
    chk("usb_lock", rd[OCC_USBLK_BIT], 32'h1);
    rdr(OCC_OSC_CTRL_OFS);
    chk("cf_clr", rd[OCC_FAIL_BIT], 32'h0);
    divisor_ready_in <= 1'h0;
    unl_wr(OCC_OSC_CTRL_OFS, ow(2'h3, 3'h1, 8'h80));
    rdr(OCC_OSC_CTRL_OFS);
    chk("pbdiv_refused", rd[OCC_PBDIV_LSB +: 2], 32'h1);
    chk("div_ready", rd[OCC_DIVRDY_BIT], 32'h0);
    divisor_ready_in <= 1'h1;
    $display("test status done");
    wr(OCC_REF_CTRL_OFS, 32'h0000_9002);
    wr(OCC_REF_CTRL_OFS, 32'h0005_9002);
    rdr(OCC_REF_CTRL_OFS);
    chk("oe_b_on", ref_clock_out_oe_b, 32'h0);
    chk("div_pending", rd[OCC_RDIV_LSB +: 15], 32'h0);
    wr(OCC_REF_CTRL_OFS, 32'h0005_9202);
    rdr(OCC_REF_CTRL_OFS);
    chk("div_applied", rd[OCC_RDIV_LSB +: 15], 32'h5);
    chk("div_switch", rd[OCC_DSW_BIT], 32'h0);
    @(negedge mclk);
    rd[0] = ref_clock_out_pin;
    repeat (6) @(negedge mclk);
    chk("ref_pin", ref_clock_out_pin, !rd[0]);
    wr(OCC_REF_CTRL_OFS, 32'h0005_9009);
    rdr(OCC_REF_CTRL_OFS);
    chk("sel_reserved", rd[3:0], 32'h2);
    ref_request <= 1'h1;
    wr(OCC_REF_CTRL_OFS, 32'h0005_9003);
    rdr(OCC_REF_CTRL_OFS);
    chk("active", rd[OCC_ACT_BIT], 32'h1);
    chk("sel_active", rd[3:0], 32'h2);
    ref_request <= 1'h0;
    wr(OCC_REF_CTRL_OFS, 32'h0005_8002);
    rdr(OCC_REF_CTRL_OFS);
    chk("oe_b_off", ref_clock_out_oe_b, 32'h1);
    $display("test reference done");
    rdr(8'h40);
    chk("rresp", rr, 32'h2);
    chk("rdata", rd, 32'h0);
    wr(8'h44, 32'h0);
    chk("bresp", br, 32'h2);
    cfg_periph_divisor_default <= 2'h0;
    cfg_pll_multiplier_default <= 3'h1;
    por_b <= 1'h0;
    @(posedge mclk);
    por_b <= 1'h1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk("por_div", periph_bus_divisor, 32'h0);
    chk("por_mul", pll_multiplier, 32'h1);
    repeat (4) @(posedge mclk);
    $display("test power-on done");
    give_verdict();
  end
endmodule
`default_nettype wire
